/* rst_seq_defs.svh */
`ifndef RST_SEQ_DEFS_SVH
`define RST_SEQ_DEFS_SVH
// What this block does
// - lun reset on task function code 08h
// - link hard reset is its own source
// - catastrophic error reset acts like power-on
// - power-up runs first, then startup
// - reset during power-up restarts power-up
// - auto-start reset restarts only startup
// - reset mid-sector finishes sector, blocks writes
// - bus or target reset flushes all segments
// - eight power-on diagnostic steps in order
// - no spin-up: steps five-eight await start
// - late fault checks next non-exempt command
// - inquiry, report luns, sense always good
// - faults never stop the diagnostic run
// - early fault may block selection response
// - self-test bit: good or check condition
// - self-test: spin, write-read-compare, 256 seeks
// - compare step repeats for every head
`define TMF_LUN_RESET 8'h08
`define DIAG_STEP_COUNT 4'h8
`define DIAG_CTRL_STEP 3'h2
`define DIAG_SPIN_STEP 3'h4
`define SEEK_COUNT 9'h100
`define STATUS_GOOD 8'h00
`define STATUS_CHECK 8'h02
`define OP_INQUIRY 8'h12
`define OP_REQ_SENSE 8'h03
`define OP_REPORT_LUNS 8'hA0
`endif

/* rst_seq_pkg.sv */
package rst_seq_pkg;
	typedef enum logic [2:0] {
		ST_IDLE, ST_POWERUP, ST_WAIT_SPIN, ST_STARTUP, ST_READY, ST_SELFTEST
	} seq_state_t;
	typedef enum logic [1:0] {
		ST_SPIN, ST_WRC, ST_SEEK
	} test_phase_t;
endpackage

/* step_runner.sv */
`timescale 1ns/1ns
`include "rst_seq_defs.svh"
module step_runner (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	// control
	input wire logic start_i,
	input wire logic [3:0] first_i,
	input wire logic [3:0] last_i,
	// step engine
	output logic step_req_o,
	output logic [2:0] step_idx_o,
	input wire logic step_done_i,
	input wire logic step_fail_i,
	// result
	output logic busy_o,
	output logic done_o,
	output logic fail_o,
	output logic early_fail_o
);
	typedef struct packed {
		logic busy;
		logic [3:0] idx;
		logic [3:0] last;
		logic done;
		logic fail;
		logic early;
	} run_t;
	run_t r_reg, r_next;
	always_comb begin
		r_next = r_reg;
		r_next.done = 1'b0;
		if (start_i) begin
			r_next.busy = 1'b1;
			r_next.idx = first_i;
			r_next.last = last_i;
			r_next.fail = 1'b0;
		end else if (r_reg.busy && step_done_i) begin
			// a fault is noted but the run carries on
			if (step_fail_i) begin
				r_next.fail = 1'b1;
				if (r_reg.idx[2:0] <= `DIAG_CTRL_STEP)
					r_next.early = 1'b1;
			end
			if (r_reg.idx == r_reg.last) begin
				r_next.busy = 1'b0;
				r_next.done = 1'b1;
			end else begin
				r_next.idx = r_reg.idx + 4'h1;
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			r_reg <= '0;
		else if (ce_i)
			r_reg <= r_next;
	end
	assign step_req_o = r_reg.busy;
	assign step_idx_o = r_reg.idx[2:0];
	assign busy_o = r_reg.busy;
	assign done_o = r_reg.done;
	assign fail_o = r_reg.fail;
	assign early_fail_o = r_reg.early;
endmodule

/* reset_and_selftest_sequencer.sv */
`timescale 1ns/1ns
`include "rst_seq_defs.svh"
module reset_and_selftest_sequencer
	import rst_seq_pkg::*;
#(
	parameter int HEADS = 2
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	// reset sources
	input wire logic por_i,
	input wire logic fatal_err_i,
	input wire logic link_hard_rst_i,
	input wire logic tmf_valid_i,
	input wire logic [7:0] tmf_code_i,
	// options
	input wire logic auto_spinup_i,
	input wire logic auto_start_i,
	// medium write
	input wire logic sector_writing_i,
	input wire logic sector_end_i,
	output logic write_enable_o,
	// diagnostic step engine
	output logic step_req_o,
	output logic [2:0] step_idx_o,
	input wire logic step_done_i,
	input wire logic step_fail_i,
	// startup engine
	output logic startup_req_o,
	input wire logic startup_done_i,
	// self-test engine
	output logic test_req_o,
	output rst_seq_pkg::test_phase_t test_phase_o,
	output logic [7:0] test_arg_o,
	input wire logic test_done_i,
	input wire logic test_fail_i,
	// commands
	input wire logic cmd_valid_i,
	input wire logic [7:0] cmd_op_i,
	input wire logic cmd_start_unit_i,
	input wire logic cmd_selftest_i,
	output logic stat_valid_o,
	output logic [7:0] stat_o,
	// state
	output logic buf_flush_o,
	output logic ready_o,
	output logic selection_ok_o,
	output logic [1:0] rst_src_o
);
	import rst_seq_pkg::*;
	typedef struct packed {
		seq_state_t st;
		logic pu_done;
		logic fault;
		logic wr_block;
		logic wr_stop;
		logic flush;
		logic stat_v;
		logic [7:0] stat;
		logic [1:0] src;
		logic runner_go;
		logic [3:0] first;
		logic [3:0] last;
		logic t_req;
		test_phase_t phase;
		logic [8:0] cnt;
		logic t_fail;
		logic st_pending;
	} seq_t;
	seq_t s_reg, s_next;
	logic run_busy, run_done, run_fail, run_early;
	logic lun_rst, hard_rst, full_rst, exempt;

	step_runner u_run (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.ce_i(ce_i),
		.start_i(s_reg.runner_go),
		.first_i(s_reg.first),
		.last_i(s_reg.last),
		.step_req_o(step_req_o),
		.step_idx_o(step_idx_o),
		.step_done_i(step_done_i),
		.step_fail_i(step_fail_i),
		.busy_o(run_busy),
		.done_o(run_done),
		.fail_o(run_fail),
		.early_fail_o(run_early)
	);

	assign lun_rst = tmf_valid_i && (tmf_code_i == `TMF_LUN_RESET);
	assign hard_rst = link_hard_rst_i;
	assign full_rst = por_i || fatal_err_i;
	assign exempt = (cmd_op_i == `OP_INQUIRY) || (cmd_op_i == `OP_REQ_SENSE)
		|| (cmd_op_i == `OP_REPORT_LUNS);

	always_comb begin
		s_next = s_reg;
		s_next.runner_go = 1'b0;
		s_next.flush = 1'b0;
		s_next.stat_v = 1'b0;
		// the current sector completes before writing stops
		if (s_reg.wr_block && sector_end_i)
			s_next.wr_stop = 1'b1;
		if (s_reg.wr_block && !sector_writing_i) begin
			s_next.wr_block = 1'b0;
			s_next.wr_stop = 1'b0;
		end
		case (s_reg.st)
			ST_IDLE: begin
				s_next.runner_go = 1'b1;
				s_next.first = 4'h0;
				s_next.last = auto_spinup_i ? (`DIAG_STEP_COUNT - 4'h1) : 4'h3;
				s_next.st = ST_POWERUP;
			end
			ST_POWERUP: begin
				if (run_done) begin
					s_next.pu_done = auto_spinup_i;
					s_next.st = auto_spinup_i ? ST_STARTUP : ST_WAIT_SPIN;
				end
			end
			ST_WAIT_SPIN: begin
				if (cmd_valid_i && cmd_start_unit_i && !run_busy && !s_reg.runner_go) begin
					s_next.runner_go = 1'b1;
					s_next.first = {1'b0, `DIAG_SPIN_STEP};
					s_next.last = `DIAG_STEP_COUNT - 4'h1;
				end
				if (run_done && s_reg.first[2]) begin
					s_next.pu_done = 1'b1;
					s_next.st = ST_STARTUP;
				end
			end
			ST_STARTUP: begin
				if (startup_done_i)
					s_next.st = ST_READY;
			end
			ST_READY: begin
				if (cmd_valid_i && cmd_selftest_i && !exempt) begin
					s_next.st = ST_SELFTEST;
					s_next.t_req = 1'b1;
					s_next.phase = ST_SPIN;
					s_next.cnt = 9'h0;
					s_next.t_fail = 1'b0;
				end
			end
			ST_SELFTEST: begin
				if (test_done_i) begin
					s_next.t_fail = s_reg.t_fail | test_fail_i;
					s_next.cnt = s_reg.cnt + 9'h1;
					case (s_reg.phase)
						ST_SPIN: begin
							s_next.phase = ST_WRC;
							s_next.cnt = 9'h0;
						end
						ST_WRC: begin
							// one pass per head
							if (s_reg.cnt == 9'(HEADS - 1)) begin
								s_next.phase = ST_SEEK;
								s_next.cnt = 9'h0;
							end
						end
						default: begin
							if (s_reg.cnt == `SEEK_COUNT - 9'h1) begin
								s_next.t_req = 1'b0;
								s_next.st = ST_READY;
								s_next.stat_v = 1'b1;
								s_next.stat = (s_reg.t_fail | test_fail_i) ?
									`STATUS_CHECK : `STATUS_GOOD;
							end
						end
					endcase
				end
			end
			default: s_next.st = ST_IDLE;
		endcase
		// commands other than a self-test from ready and a start unit awaiting spin-up answered here
		if (cmd_valid_i && !(s_reg.st == ST_READY && cmd_selftest_i && !exempt)
			&& !(s_reg.st == ST_WAIT_SPIN && cmd_start_unit_i)) begin
			s_next.stat_v = 1'b1;
			if (exempt) begin
				s_next.stat = `STATUS_GOOD;
			end else if (s_next.fault) begin
				s_next.stat = `STATUS_CHECK;
				s_next.fault = 1'b0;
			end else begin
				s_next.stat = `STATUS_GOOD;
			end
		end
		// a new fault outlives a report in the same cycle
		if (run_done && run_fail)
			s_next.fault = 1'b1;
		if (lun_rst || hard_rst) begin
			s_next.flush = 1'b1;
			s_next.src = lun_rst ? 2'h3 : 2'h2;
			if (s_reg.st == ST_SELFTEST) begin
				s_next.st = ST_READY;
				s_next.t_req = 1'b0;
			end
		end
		if (full_rst) begin
			s_next.src = por_i ? 2'h0 : 2'h1;
			s_next.flush = 1'b1;
			s_next.t_req = 1'b0;
			if (sector_writing_i)
				s_next.wr_block = 1'b1;
			if (!s_reg.pu_done) begin
				s_next.st = ST_IDLE;
			end else if (auto_start_i && s_reg.st != ST_READY) begin
				// power-up already done, only startup reruns
				s_next.st = ST_STARTUP;
			end else begin
				s_next.st = ST_STARTUP;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			s_reg <= '0;
		else if (ce_i)
			s_reg <= s_next;
	end

	// writing stops only at a sector boundary to keep the medium intact
	assign write_enable_o = !s_reg.wr_stop;
	assign startup_req_o = (s_reg.st == ST_STARTUP);
	assign test_req_o = s_reg.t_req;
	assign test_phase_o = s_reg.phase;
	assign test_arg_o = s_reg.cnt[7:0];
	assign stat_valid_o = s_reg.stat_v;
	assign stat_o = s_reg.stat;
	assign buf_flush_o = s_reg.flush;
	assign ready_o = (s_reg.st == ST_READY);
	assign selection_ok_o = !run_early;
	assign rst_src_o = s_reg.src;

	a_flush_lun: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		ce_i && lun_rst |=> buf_flush_o)
		else $error("lun reset did not flush buffer");
	a_exempt_good: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		ce_i && cmd_valid_i && exempt && s_reg.st != ST_SELFTEST |=> stat_o == `STATUS_GOOD)
		else $error("exempt command not good");
	a_pu_restart: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		ce_i && full_rst && !s_reg.pu_done |=> s_reg.st == ST_IDLE)
		else $error("power-up not restarted");
	a_start_only: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		ce_i && full_rst && s_reg.pu_done |=> s_reg.st == ST_STARTUP)
		else $error("startup not restarted");
	a_fault_check: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		ce_i && cmd_valid_i && !exempt && s_reg.fault && s_reg.st != ST_SELFTEST
		&& s_reg.st != ST_WAIT_SPIN && !(s_reg.st == ST_READY && cmd_selftest_i)
		|=> stat_valid_o && stat_o == `STATUS_CHECK)
		else $error("fault not reported");
	a_fault_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		ce_i && cmd_valid_i && !exempt && s_reg.fault && !run_done
		&& s_reg.st == ST_READY && !cmd_selftest_i |=> !s_reg.fault)
		else $error("fault not cleared");
	a_wr_block: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		ce_i && s_reg.wr_block && sector_end_i && sector_writing_i |=> !write_enable_o)
		else $error("write not blocked");
	a_wr_finish: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		ce_i && full_rst && sector_writing_i && !s_reg.wr_block && !s_reg.wr_stop
		|=> write_enable_o)
		else $error("sector cut short");
	a_lun_code: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		ce_i && tmf_valid_i && tmf_code_i == `TMF_LUN_RESET && !full_rst |=> rst_src_o == 2'h3)
		else $error("lun reset source wrong");
endmodule

/* rst_seq_partner.sv */
`timescale 1ns/1ns
module rst_seq_partner (
	// clock
	input wire logic clk_i,
	// fault injection, bit 3 set means none
	input wire logic [3:0] fail_step_i,
	input wire logic [1:0] fail_phase_i,
	// step engine
	input wire logic step_req_i,
	input wire logic [2:0] step_idx_i,
	output logic step_done_o,
	output logic step_fail_o,
	// startup engine
	input wire logic startup_req_i,
	output logic startup_done_o,
	// self-test engine
	input wire logic test_req_i,
	input wire logic [1:0] test_phase_i,
	output logic test_done_o,
	output logic test_fail_o
);
	int sc = 0;
	int uc = 0;
	int tc = 0;
	bit slow = 0;
	initial {step_done_o, step_fail_o, startup_done_o, test_done_o, test_fail_o} = 5'h00;
	// prompt and slow step answers alternate so spacing is exercised
	always @(negedge clk_i) begin
		{step_done_o, step_fail_o, startup_done_o, test_done_o, test_fail_o} <= 5'h00;
		sc <= step_req_i ? sc + 1 : 0;
		uc <= startup_req_i ? uc + 1 : 0;
		tc <= test_req_i ? tc + 1 : 0;
		if (step_req_i && sc >= (slow ? 3 : 0)) begin
			step_done_o <= 1'b1;
			step_fail_o <= !fail_step_i[3] && step_idx_i == fail_step_i[2:0];
			sc <= 0;
			slow <= !slow;
		end
		// long startup leaves room for a reset in mid-run
		if (startup_req_i && uc >= 20) begin
			startup_done_o <= 1'b1;
			uc <= 0;
		end
		if (test_req_i && tc >= 1) begin
			test_done_o <= 1'b1;
			test_fail_o <= test_phase_i == fail_phase_i;
			tc <= 0;
		end
	end
endmodule

/* reset_and_selftest_sequencer_bench.sv */
`timescale 1ns/1ns
`include "rst_seq_defs.svh"
module reset_and_selftest_sequencer_bench;
	import rst_seq_pkg::*;
	localparam int HEADS = 3;
	logic clk_i = 0, sys_rst_i = 1, ce_i = 1, por_i = 0, fatal_err_i = 0, link_hard_rst_i = 0;
	logic tmf_valid_i = 0, auto_spinup_i = 1, auto_start_i = 1, sector_writing_i = 0;
	logic sector_end_i = 0, cmd_valid_i = 0, cmd_start_unit_i = 0, cmd_selftest_i = 0;
	logic [7:0] tmf_code_i = 8'h00, cmd_op_i = 8'h00, test_arg_o, stat_o;
	logic [3:0] fail_step = 4'h8;
	logic [1:0] fail_phase = 2'h3, rst_src_o, last_ph;
	logic write_enable_o, step_req_o, step_done_i, step_fail_i, startup_req_o, startup_done_i;
	logic test_req_o, test_done_i, test_fail_i, stat_valid_o, buf_flush_o, ready_o, selection_ok_o;
	logic [2:0] step_idx_o;
	test_phase_t test_phase_o;
	int fail_count = 0, comparisons = 0, cyc = 0, flushes = 0, su_steps = 0;
	int ph_cnt[4];
	bit ph_back = 0;
	logic [2:0] log_q[$];
	reset_and_selftest_sequencer #(.HEADS(HEADS)) reset_and_selftest_sequencer_inst (.*);
	rst_seq_partner rst_seq_partner_inst (.clk_i(clk_i), .fail_step_i(fail_step),
		.fail_phase_i(fail_phase), .step_req_i(step_req_o), .step_idx_i(step_idx_o),
		.step_done_o(step_done_i), .step_fail_o(step_fail_i), .startup_req_i(startup_req_o),
		.startup_done_o(startup_done_i), .test_req_i(test_req_o), .test_phase_i(test_phase_o),
		.test_done_o(test_done_i), .test_fail_o(test_fail_i));
	initial forever #4 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		// a done taken with a reset request may be discarded
		if (step_req_o && step_done_i && !por_i && !fatal_err_i) log_q.push_back(step_idx_o);
		if (startup_req_o && startup_done_i) su_steps = log_q.size();
		if (test_req_o && test_done_i) ph_cnt[test_phase_o]++;
		if (test_req_o && test_phase_o < last_ph) ph_back = 1;
		last_ph <= test_req_o ? test_phase_o : 2'h0;
		if (buf_flush_o) flushes++;
		if (cyc == 40000) begin
			fail_count++;
			results();
		end
	end
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		tick(1);
		s = 0;
	endtask
	task automatic hw_reset();
		sys_rst_i = 1;
		tick(16);
		sys_rst_i = 0;
		log_q.delete();
	endtask
	task automatic wait_ready();
		int n = 0;
		while (ready_o !== 1'b1 && n < 3000) begin
			tick(1);
			n++;
		end
		chk(ready_o, 16'h0001);
	endtask
	task automatic chk_log();
		chk(log_q.size(), 16'h0008);
		foreach (log_q[i]) chk(log_q[i], i);
	endtask
	task automatic cmd(input logic [7:0] op, input logic st, input logic [7:0] exp);
		int n = 0;
		cmd_op_i = op;
		cmd_selftest_i = st;
		pulse(cmd_valid_i);
		while (stat_valid_o !== 1'b1 && n < 2000) begin
			tick(1);
			n++;
		end
		chk({7'h00, stat_valid_o, stat_o}, {8'h01, exp});
		tick(1);
	endtask
	task automatic t_powerup();
		int n = 0;
		while (!(step_req_o === 1'b1 && step_idx_o === 3'h3) && n < 500) begin
			tick(1);
			n++;
		end
		pulse(por_i);
		// dones around the restart belong to the aborted run
		tick(2);
		log_q.delete();
		wait_ready();
		chk_log();
		chk(su_steps, 16'h0008);
		chk(rst_src_o, 16'h0000);
		$display("test powerup done");
	endtask
	task automatic src(ref logic s, input logic [1:0] exp, input int fl);
		flushes = 0;
		pulse(s);
		tick(4);
		chk(rst_src_o, exp);
		chk(flushes, fl);
		wait_ready();
	endtask
	task automatic t_sources();
		tmf_code_i = 8'h01;
		src(tmf_valid_i, 2'h0, 0);
		src(link_hard_rst_i, 2'h2, 1);
		ce_i = 0;
		src(link_hard_rst_i, 2'h2, 0);
		ce_i = 1;
		tmf_code_i = `TMF_LUN_RESET;
		src(tmf_valid_i, 2'h3, 1);
		$display("test sources done");
	endtask
	task automatic t_startup();
		int n = 0;
		log_q.delete();
		pulse(fatal_err_i);
		while (startup_req_o !== 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
		tick(5);
		pulse(fatal_err_i);
		wait_ready();
		chk(rst_src_o, 16'h0001);
		chk(log_q.size(), 16'h0000);
		$display("test startup done");
	endtask
	task automatic t_fault(input logic [3:0] step, input logic sel);
		fail_step = step;
		hw_reset();
		wait_ready();
		fail_step = 4'h8;
		chk_log();
		chk(selection_ok_o, sel);
		if (sel) begin
			cmd(`OP_INQUIRY, 0, `STATUS_GOOD);
			cmd(`OP_REPORT_LUNS, 0, `STATUS_GOOD);
			cmd(`OP_REQ_SENSE, 0, `STATUS_GOOD);
			cmd(8'h00, 0, `STATUS_CHECK);
			cmd(8'h00, 0, `STATUS_GOOD);
		end
		$display("test fault done");
	endtask
	task automatic t_nospin();
		auto_spinup_i = 0;
		hw_reset();
		tick(150);
		chk(log_q.size(), 16'h0004);
		chk(ready_o, 16'h0000);
		cmd_op_i = 8'h1B;
		cmd_start_unit_i = 1;
		pulse(cmd_valid_i);
		cmd_start_unit_i = 0;
		wait_ready();
		chk_log();
		auto_spinup_i = 1;
		$display("test nospin done");
	endtask
	task automatic t_selftest(input logic [1:0] fp, input logic [7:0] exp);
		fail_phase = fp;
		ph_cnt = '{0, 0, 0, 0};
		cmd(8'h1D, 1, exp);
		fail_phase = 2'h3;
		if (fp == 2'h3) begin
			chk(ph_cnt[0], 16'h0001);
			chk(ph_cnt[1], HEADS);
			chk(ph_cnt[2], `SEEK_COUNT);
			chk(ph_back, 16'h0000);
		end
		$display("test selftest done");
	endtask
	task automatic t_write();
		sector_writing_i = 1;
		tick(2);
		pulse(por_i);
		tick(3);
		chk(write_enable_o, 16'h0001);
		pulse(sector_end_i);
		tick(2);
		chk(write_enable_o, 16'h0000);
		sector_writing_i = 0;
		tick(2);
		chk(write_enable_o, 16'h0001);
		wait_ready();
		$display("test write done");
	endtask
	initial begin
		hw_reset();
		t_powerup();
		t_sources();
		t_startup();
		t_fault(4'h5, 1'b1);
		t_fault(4'h1, 1'b0);
		t_nospin();
		t_selftest(2'h3, `STATUS_GOOD);
		t_selftest(2'h1, `STATUS_CHECK);
		t_write();
		results();
	end
endmodule
